// File: rtl/ffmlmu_pkg.sv
// Constants and types shared by the floating-point fused MAC, load and move slice
package ffmlmu_pkg;
    // ======================================================================
    // Register file and software port
    localparam int REG_NUM = 32;
    localparam int DATA_W = 32;
    localparam logic [5:0] PORT_CTRL_ADDR = 6'h20;
    localparam logic [5:0] PORT_STAT_ADDR = 6'h21;
    localparam logic [5:0] PORT_FPR_LAST = 6'h1F;
    localparam logic [1:0] RMODE_RESET = 2'h0;
    // ======================================================================
    // Rounding modes
    localparam logic [1:0] RM_RNE = 2'h0;
    localparam logic [1:0] RM_RP = 2'h1;
    localparam logic [1:0] RM_RM = 2'h2;
    localparam logic [1:0] RM_RZ = 2'h3;
    // ======================================================================
    // Single-precision format
    localparam logic [7:0] EXP_MAX = 8'hFF;
    localparam logic signed [11:0] EXP_BIAS = 12'sh07F;
    localparam logic signed [11:0] EXP_OVF = 12'sh0FF;
    localparam logic signed [11:0] EXP_ZERO = 12'sh000;
    localparam logic signed [11:0] EXP_ONE = 12'sh001;
    localparam logic [31:0] FP_ONE = 32'h3F800000;
    localparam logic [31:0] FP_POS_ZERO = 32'h00000000;
    localparam logic [31:0] FP_QNAN = 32'h7FC00000;
    localparam logic [30:0] FP_INF_MAG = 31'h7F800000;
    localparam logic [30:0] FP_MAX_MAG = 31'h7F7FFFFF;
    // ======================================================================
    // Fused datapath window: carry bit, 48-bit product field, guard bits
    localparam int SUM_W = 76;
    localparam int GUARD_W = 27;
    localparam logic [6:0] SUM_MSB = 7'h4B;
    localparam logic signed [11:0] LEAD_POS = 12'sh04A;
    localparam logic [11:0] SHIFT_LIMIT = 12'h04C;
    // ======================================================================
    // Load addressing
    localparam logic [31:0] WORD_BYTES = 32'h00000004;
    localparam logic [5:0] WORDS_SINGLE = 6'h01;
    localparam logic [5:0] WORDS_DOUBLE = 6'h02;
    localparam logic [5:0] LIST_DBL_MAX = 6'h10;
    // ======================================================================
    // Condition codes and core flag positions
    localparam logic [3:0] CC_EQ = 4'h0;
    localparam logic [3:0] CC_NE = 4'h1;
    localparam logic [3:0] CC_CS = 4'h2;
    localparam logic [3:0] CC_CC = 4'h3;
    localparam logic [3:0] CC_MI = 4'h4;
    localparam logic [3:0] CC_PL = 4'h5;
    localparam logic [3:0] CC_VS = 4'h6;
    localparam logic [3:0] CC_VC = 4'h7;
    localparam logic [3:0] CC_HI = 4'h8;
    localparam logic [3:0] CC_LS = 4'h9;
    localparam logic [3:0] CC_GE = 4'hA;
    localparam logic [3:0] CC_LT = 4'hB;
    localparam logic [3:0] CC_GT = 4'hC;
    localparam logic [3:0] CC_LE = 4'hD;
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_C = 1;
    localparam int FLAG_V = 0;
    // ======================================================================
    // Operations and states
    typedef enum logic [3:0] {
        OP_FUSED_MUL_ACC, OP_FUSED_MUL_SUB, OP_FUSED_NEG_MUL_ACC, OP_FUSED_NEG_MUL_SUB,
        OP_CHAINED_MUL_ACC, OP_CHAINED_MUL_SUB, OP_BLOCK_REG_LOAD, OP_SINGLE_REG_LOAD,
        OP_MOVE_IMM, OP_MOVE_REG
    } ffmlmu_op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CHAIN, ST_LOAD} ffmlmu_state_t;
endpackage

// File: rtl/ffmlmu_core.sv
// Floating-point fused multiply-accumulate, extension-register load and move slice
`timescale 1ns/1ps
// Behaviour
// - fused accumulate adds a*b into destination
// - product kept exact, one rounding at end
// - fused subtract computes d plus (-a)*b
// - negated accumulate computes (-a)*b minus d
// - negated subtract computes a*b minus d
// - block load fills consecutive registers from memory
// - increment-after starts at base address
// - decrement-before ends just below base address
// - write-back stores updated base; decrement-before needs it
// - stack pointer accepted as base register
// - single load reads one single or double register
// - offset multiple of 4, magnitude up to 1020
// - chained accumulate adds product to destination
// - chained subtract takes product from destination
// - immediate move writes encoded constant to register
// - register move copies double or single word
// - every operation gated by condition code
module ffmlmu_core
    import ffmlmu_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire ffmlmu_op_t cmd_op_in,
    input wire logic [3:0] cmd_cond_in,
    input wire logic [3:0] core_flags_in,
    input wire logic cmd_double_in,
    input wire logic [4:0] single_dest_reg_in,
    input wire logic [4:0] first_source_reg_in,
    input wire logic [4:0] second_source_reg_in,
    input wire logic [3:0] double_dest_reg_in,
    input wire logic [3:0] double_source_reg_in,
    input wire logic [31:0] base_register_in,
    input wire logic increment_after_in,
    input wire logic write_back_in,
    input wire logic [5:0] list_count_in,
    input wire logic [7:0] imm_in,
    input wire logic imm_add_in,
    input wire logic [31:0] mem_rdata_in,
    input wire logic mem_rvalid_in,
    input wire logic [5:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic cmd_ready_out,
    output logic done_out,
    output logic mem_req_out,
    output logic [31:0] mem_addr_out,
    output logic base_wb_valid_out,
    output logic [31:0] base_wb_data_out,
    output logic [31:0] reg_rdata_out
);
    typedef struct packed {
        ffmlmu_state_t st;
        logic [REG_NUM-1:0][DATA_W-1:0] fpr;
        logic [1:0] rmode;
        logic [31:0] prod, addr, wb_addr, wb_data, rdata;
        logic [4:0] cdst, ptr;
        logic [5:0] left;
        logic csub, wb, wb_valid, done, cond_fail;
    } ffmlmu_rec_t;

    ffmlmu_rec_t cur, next_cur;

    // ======================================================================
    // Condition evaluation against core flags
    function automatic logic cond_pass(input logic [3:0] cc, input logic [3:0] f);
        if (cc == CC_EQ) cond_pass = f[FLAG_Z];
        else if (cc == CC_NE) cond_pass = !f[FLAG_Z];
        else if (cc == CC_CS) cond_pass = f[FLAG_C];
        else if (cc == CC_CC) cond_pass = !f[FLAG_C];
        else if (cc == CC_MI) cond_pass = f[FLAG_N];
        else if (cc == CC_PL) cond_pass = !f[FLAG_N];
        else if (cc == CC_VS) cond_pass = f[FLAG_V];
        else if (cc == CC_VC) cond_pass = !f[FLAG_V];
        else if (cc == CC_HI) cond_pass = f[FLAG_C] && !f[FLAG_Z];
        else if (cc == CC_LS) cond_pass = !f[FLAG_C] || f[FLAG_Z];
        else if (cc == CC_GE) cond_pass = (f[FLAG_N] == f[FLAG_V]);
        else if (cc == CC_LT) cond_pass = (f[FLAG_N] != f[FLAG_V]);
        else if (cc == CC_GT) cond_pass = !f[FLAG_Z] && (f[FLAG_N] == f[FLAG_V]);
        else if (cc == CC_LE) cond_pass = f[FLAG_Z] || (f[FLAG_N] != f[FLAG_V]);
        else cond_pass = 1'b1;
    endfunction

    // ======================================================================
    // Fused multiply-add: (+/-a)*b + (+/-c), exact product, one rounding.
    // Subnormals flush to zero and any Inf/NaN operand gives the default NaN,
    // trading full IEEE special handling for a compact datapath.
    function automatic logic [31:0] fma(input logic [31:0] a, input logic [31:0] b,
                                         input logic [31:0] c, input logic neg_p,
                                         input logic neg_c, input logic [1:0] rm);
        logic sp, sc, sb, ss, sr, pz, cz, usep, inc, rb, st;
        logic [47:0] mp, mc;
        logic signed [11:0] tp, tc, tr, er, dd;
        logic [11:0] d;
        logic [SUM_W-1:0] big, sml, sum, norm;
        logic [6:0] lo;
        logic [24:0] m;
        sp = a[31] ^ b[31] ^ neg_p;
        sc = c[31] ^ neg_c;
        pz = (a[30:23] == '0) || (b[30:23] == '0);
        cz = (c[30:23] == '0);
        mp = pz ? '0 : {1'b1, a[22:0]} * {1'b1, b[22:0]};
        mc = cz ? '0 : {1'b0, 1'b1, c[22:0], 23'h000000};
        tp = $signed({4'h0, a[30:23]}) + $signed({4'h0, b[30:23]}) - EXP_BIAS + EXP_ONE;
        tc = $signed({4'h0, c[30:23]}) + EXP_ONE;
        usep = cz || (!pz && (tp >= tc));
        big = usep ? {1'b0, mp, {GUARD_W{1'b0}}} : {1'b0, mc, {GUARD_W{1'b0}}};
        sml = usep ? {1'b0, mc, {GUARD_W{1'b0}}} : {1'b0, mp, {GUARD_W{1'b0}}};
        tr = usep ? tp : tc;
        sb = usep ? sp : sc;
        ss = usep ? sc : sp;
        dd = usep ? (tp - tc) : (tc - tp);
        d = (dd < EXP_ZERO) ? '0 : dd;
        if (d >= SHIFT_LIMIT)
            sml = {{(SUM_W-1){1'b0}}, |sml};
        else
            sml = (sml >> d) | {{(SUM_W-1){1'b0}}, |(sml & ~({SUM_W{1'b1}} << d))};
        sr = sb;
        if (sb == ss)
            sum = big + sml;
        else if (big >= sml)
            sum = big - sml;
        else
        begin
            sum = sml - big;
            sr = ss;
        end
        lo = '0;
        for (int i = 0; i < SUM_W; i++)
            if (sum[i])
                lo = 7'(i);
        norm = sum << (SUM_MSB - lo);
        m = {1'b0, norm[SUM_W-1 -: 24]};
        rb = norm[SUM_W-25];
        st = |norm[SUM_W-26:0];
        er = tr + $signed({5'h00, lo}) - LEAD_POS;
        if (rm == RM_RNE) inc = rb && (st || m[0]);
        else if (rm == RM_RP) inc = !sr && (rb || st);
        else if (rm == RM_RM) inc = sr && (rb || st);
        else inc = 1'b0;
        m = m + {24'h000000, inc};
        if (m[24])
            er = er + EXP_ONE;
        if ((a[30:23] == EXP_MAX) || (b[30:23] == EXP_MAX) || (c[30:23] == EXP_MAX))
            fma = FP_QNAN;
        else if (sum == '0)
            fma = {(sb == ss) ? sb : (rm == RM_RM), 31'h00000000};
        else if (er >= EXP_OVF)
            fma = {sr, ((rm == RM_RNE) || (rm == RM_RP && !sr) || (rm == RM_RM && sr))
                       ? FP_INF_MAG : FP_MAX_MAG};
        else if (er <= EXP_ZERO)
            fma = {sr, 31'h00000000};
        else
            fma = {sr, er[7:0], m[22:0]};
    endfunction

    // ======================================================================
    // Next-state logic
    logic [31:0] opa, opb, opd, off;
    logic [5:0] words;
    logic [4:0] sdst, ddst, dsrc;

    always_comb
    begin
        next_cur = cur;
        next_cur.done = 1'b0;
        next_cur.wb_valid = 1'b0;
        opa = cur.fpr[first_source_reg_in];
        opb = cur.fpr[second_source_reg_in];
        opd = cur.fpr[single_dest_reg_in];
        sdst = single_dest_reg_in;
        ddst = {double_dest_reg_in, 1'b0};
        dsrc = {double_source_reg_in, 1'b0};
        off = {22'h000000, imm_in, 2'h0};
        words = cmd_double_in ? WORDS_DOUBLE : WORDS_SINGLE;
        // Software port; the datapath below overrides a same-cycle register write
        next_cur.rdata = '0;
        if (reg_rd_in)
        begin
            if (reg_addr_in <= PORT_FPR_LAST)
                next_cur.rdata = cur.fpr[reg_addr_in[4:0]];
            else if (reg_addr_in == PORT_CTRL_ADDR)
                next_cur.rdata = {30'h00000000, cur.rmode};
            else if (reg_addr_in == PORT_STAT_ADDR)
                next_cur.rdata = {30'h00000000, cur.cond_fail, cur.st != ST_IDLE};
        end
        if (reg_wr_in)
        begin
            if (reg_addr_in <= PORT_FPR_LAST)
                next_cur.fpr[reg_addr_in[4:0]] = reg_wdata_in;
            else if (reg_addr_in == PORT_CTRL_ADDR)
                next_cur.rmode = reg_wdata_in[1:0];
        end
        case (cur.st)
            ST_IDLE:
            begin
                if (cmd_valid_in)
                begin
                    next_cur.cond_fail = !cond_pass(cmd_cond_in, core_flags_in);
                    next_cur.done = 1'b1;
                    if (!next_cur.cond_fail)
                    begin
                        case (cmd_op_in)
                            OP_FUSED_MUL_ACC:
                                next_cur.fpr[sdst] = fma(opa, opb, opd, 1'b0, 1'b0, cur.rmode);
                            OP_FUSED_MUL_SUB:
                                next_cur.fpr[sdst] = fma(opa, opb, opd, 1'b1, 1'b0, cur.rmode);
                            OP_FUSED_NEG_MUL_ACC:
                                next_cur.fpr[sdst] = fma(opa, opb, opd, 1'b1, 1'b1, cur.rmode);
                            OP_FUSED_NEG_MUL_SUB:
                                next_cur.fpr[sdst] = fma(opa, opb, opd, 1'b0, 1'b1, cur.rmode);
                            OP_CHAINED_MUL_ACC, OP_CHAINED_MUL_SUB:
                            begin
                                // Product rounded first, accumulated next cycle
                                next_cur.prod = fma(opa, opb, FP_POS_ZERO, 1'b0, 1'b0,
                                                    cur.rmode);
                                next_cur.cdst = sdst;
                                next_cur.csub = (cmd_op_in == OP_CHAINED_MUL_SUB);
                                next_cur.done = 1'b0;
                                next_cur.st = ST_CHAIN;
                            end
                            OP_BLOCK_REG_LOAD:
                            begin
                                next_cur.ptr = cmd_double_in ? ddst : sdst;
                                next_cur.left = cmd_double_in ? 6'(list_count_in << 1)
                                                              : list_count_in;
                                // any core register value serves as base
                                if (increment_after_in)
                                    next_cur.addr = base_register_in;
                                else
                                    next_cur.addr = base_register_in
                                        - 32'(next_cur.left * WORD_BYTES);
                                next_cur.wb_addr = increment_after_in
                                    ? base_register_in + 32'(next_cur.left * WORD_BYTES)
                                    : next_cur.addr;
                                // write-back on request, forced for decrement-before
                                next_cur.wb = write_back_in || !increment_after_in;
                                next_cur.done = (next_cur.left == '0);
                                next_cur.st = (next_cur.left == '0) ? ST_IDLE : ST_LOAD;
                            end
                            OP_SINGLE_REG_LOAD:
                            begin
                                // one register, base plus optional offset
                                // word-scaled offset 0..1020, added or subtracted
                                next_cur.addr = imm_add_in ? base_register_in + off
                                                           : base_register_in - off;
                                next_cur.ptr = cmd_double_in ? ddst : sdst;
                                next_cur.left = words;
                                next_cur.wb = 1'b0;
                                next_cur.done = 1'b0;
                                next_cur.st = ST_LOAD;
                            end
                            // expand 8-bit constant to single precision
                            OP_MOVE_IMM:
                                next_cur.fpr[sdst] = {imm_in[7], !imm_in[6], {5{imm_in[6]}},
                                                      imm_in[5:0], 19'h00000};
                            // copy word or pair, source untouched
                            OP_MOVE_REG:
                                if (cmd_double_in)
                                begin
                                    next_cur.fpr[ddst] = cur.fpr[dsrc];
                                    next_cur.fpr[ddst + 5'h01] = cur.fpr[dsrc + 5'h01];
                                end
                                else
                                    next_cur.fpr[sdst] = cur.fpr[second_source_reg_in];
                            default:
                                next_cur.done = 1'b1;
                        endcase
                    end
                end
            end
            ST_CHAIN:
            begin
                next_cur.fpr[cur.cdst] = fma(cur.prod, FP_ONE, cur.fpr[cur.cdst], cur.csub,
                                             1'b0, cur.rmode);
                next_cur.done = 1'b1;
                next_cur.st = ST_IDLE;
            end
            ST_LOAD:
                if (mem_rvalid_in)
                begin
                    next_cur.fpr[cur.ptr] = mem_rdata_in;
                    next_cur.ptr = cur.ptr + 5'h01;
                    next_cur.addr = cur.addr + WORD_BYTES;
                    next_cur.left = cur.left - 6'h01;
                    if (cur.left == WORDS_SINGLE)
                    begin
                        next_cur.done = 1'b1;
                        next_cur.wb_valid = cur.wb;
                        next_cur.wb_data = cur.wb_addr;
                        next_cur.st = ST_IDLE;
                    end
                end
            default:
                next_cur.st = ST_IDLE;
        endcase
    end

    // ======================================================================
    // State register
    always_ff @(posedge mclk_in)
    begin
        if (rst_in)
        begin
            cur <= '0;
            cur.st <= ST_IDLE;
            cur.rmode <= RMODE_RESET;
        end
        else
            cur <= next_cur;
    end

    assign cmd_ready_out = (cur.st == ST_IDLE);
    assign done_out = cur.done;
    assign mem_req_out = (cur.st == ST_LOAD);
    assign mem_addr_out = cur.addr;
    assign base_wb_valid_out = cur.wb_valid;
    assign base_wb_data_out = cur.wb_data;
    assign reg_rdata_out = cur.rdata;
endmodule // ffmlmu_core

// File: bench/ffmlmu_sva.sv
// Assertion checker for the fused MAC, load and move slice
`timescale 1ns/1ps
module ffmlmu_sva
    import ffmlmu_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire ffmlmu_op_t cmd_op_in,
    input wire logic [3:0] cmd_cond_in,
    input wire logic [3:0] core_flags_in,
    input wire logic mem_rvalid_in,
    input wire logic cmd_ready_out,
    input wire logic done_out,
    input wire logic mem_req_out,
    input wire logic [31:0] mem_addr_out,
    input wire logic base_wb_valid_out
);
    // ======================================================================
    // Command and load timing
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    wire take = cmd_valid_in && cmd_ready_out;
    a_cond_skip: assert property (
        take && cmd_cond_in == CC_EQ && !core_flags_in[FLAG_Z] |=> done_out && !mem_req_out)
        else $error("failed condition still ran");
    a_fused_one: assert property (
        take && (cmd_op_in <= OP_FUSED_NEG_MUL_SUB || cmd_op_in >= OP_MOVE_IMM)
        |=> done_out && cmd_ready_out) else $error("single cycle op late");
    a_chain_two: assert property (
        take && cmd_cond_in[3:1] == 3'h7 && (cmd_op_in == OP_CHAINED_MUL_ACC
        || cmd_op_in == OP_CHAINED_MUL_SUB) |=> !cmd_ready_out && !done_out ##1 done_out)
        else $error("chained op timing wrong");
    a_req_busy: assert property (
        mem_req_out |-> !cmd_ready_out) else $error("ready during load");
    a_addr_step: assert property (
        mem_req_out && mem_rvalid_in ##1 mem_req_out |-> mem_addr_out == $past(mem_addr_out)
        + WORD_BYTES) else $error("load address not ascending");
    a_addr_hold: assert property (
        mem_req_out && !mem_rvalid_in |=> mem_req_out && $stable(mem_addr_out))
        else $error("load word dropped");
    a_load_end: assert property (
        mem_req_out && mem_rvalid_in ##1 !mem_req_out |-> done_out) else $error("load no done");
    a_wb_done: assert property (
        base_wb_valid_out |-> done_out) else $error("write-back outside done");
endmodule // ffmlmu_sva

// File: bench/ffmlmu_mem_model.sv
// Memory partner that answers load words promptly or after wait cycles
`timescale 1ns/1ps
module ffmlmu_mem_model
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic slow_in,
    input wire logic req_in,
    input wire logic [31:0] addr_in,
    output logic rvalid_out,
    output logic [31:0] rdata_out
);
    logic [1:0] gap;
    // ======================================================================
    // One word per pulse; data toggles when not valid so stale reads show
    always_ff @(posedge mclk_in)
    begin
        if (rst_in || !req_in || rvalid_out)
        begin
            rvalid_out <= 1'b0;
            gap <= slow_in ? 2'h3 : 2'h0;
            rdata_out <= rst_in ? 32'h0 : ~rdata_out;
        end
        else if (gap != 2'h0)
        begin
            gap <= gap - 2'h1;
            rdata_out <= ~rdata_out;
        end
        else
        begin
            rvalid_out <= 1'b1;
            rdata_out <= addr_in ^ 32'h5A5AF0F0;
        end
    end
endmodule // ffmlmu_mem_model

// File: bench/testbench.sv
// Self-checking bench for the fused MAC, load and move slice
`timescale 1ns/1ps
module testbench
    import ffmlmu_pkg::*;
;
    logic mclk_in = 1'b0, rst_in = 1'b1, cmd_valid_in = 1'b0, cmd_double_in = 1'b0, slow = 1'b0;
    logic increment_after_in = 1'b1, write_back_in = 1'b1, imm_add_in = 1'b1, reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0, mem_rvalid_in, cmd_ready_out, done_out, mem_req_out, base_wb_valid_out;
    ffmlmu_op_t cmd_op_in = OP_MOVE_IMM;
    logic [3:0] cmd_cond_in = 4'hE, core_flags_in = 4'h0, double_dest_reg_in = 4'h0;
    logic [3:0] double_source_reg_in = 4'h0;
    logic [4:0] single_dest_reg_in = 5'h0, first_source_reg_in = 5'h1, second_source_reg_in = 5'h2;
    logic [5:0] list_count_in = 6'h1, reg_addr_in = 6'h0;
    logic [7:0] imm_in = 8'h0;
    logic [31:0] base_register_in = 32'h0, reg_wdata_in = 32'h0, mem_rdata_in, mem_addr_out;
    logic [31:0] base_wb_data_out, reg_rdata_out, seed = 32'h000119FC, r, b;
    int bad_count = 0, samples_checked = 0;
    localparam logic [31:0] EXP [8] = '{32'h40E00000, 32'hC0A00000, 32'hC0E00000, 32'h40A00000,
        32'h40E00000, 32'hC0A00000, 32'h3A000400, 32'h3A000000};
    ffmlmu_core uut (.mclk_in, .rst_in, .cmd_valid_in, .cmd_op_in, .cmd_cond_in, .core_flags_in,
        .cmd_double_in, .single_dest_reg_in, .first_source_reg_in, .second_source_reg_in,
        .double_dest_reg_in, .double_source_reg_in, .base_register_in, .increment_after_in,
        .write_back_in, .list_count_in, .imm_in, .imm_add_in, .mem_rdata_in, .mem_rvalid_in,
        .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .cmd_ready_out, .done_out,
        .mem_req_out, .mem_addr_out, .base_wb_valid_out, .base_wb_data_out, .reg_rdata_out);
    ffmlmu_mem_model mem (.mclk_in, .rst_in, .slow_in(slow), .req_in(mem_req_out),
        .addr_in(mem_addr_out), .rvalid_out(mem_rvalid_in), .rdata_out(mem_rdata_in));
    // ======================================================================
    // Expectation helpers and bus tasks
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [31:0] mv(input logic [31:0] a);
        return a ^ 32'h5A5AF0F0;
    endfunction
    function automatic logic [31:0] fimm(input logic [7:0] i);
        return {i[7], ~i[6], {5{i[6]}}, i[5:4], i[3:0], 19'h0};
    endfunction
    function automatic logic pass(input logic [3:0] c, input logic [3:0] f);
        logic t;
        case (c[3:1])
            3'h0: t = f[2];
            3'h1: t = f[1];
            3'h2: t = f[3];
            3'h3: t = f[0];
            3'h4: t = f[1] & ~f[2];
            3'h5: t = f[3] == f[0];
            3'h6: t = ~f[2] & (f[3] == f[0]);
            default: t = 1'b0;
        endcase
        return (c[3:1] == 3'h7) ? 1'b1 : t ^ c[0];
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        @(negedge mclk_in);
        chk(reg_rdata_out, exp);
    endtask
    // Command is taken at the task's second edge, the one after valid is raised, since the unit is idle between runs
    task automatic run(input ffmlmu_op_t op);
        int n = 0;
        @(posedge mclk_in);
        cmd_op_in <= op;
        cmd_valid_in <= 1'b1;
        @(posedge mclk_in);
        cmd_valid_in <= 1'b0;
        @(negedge mclk_in);
        while (done_out !== 1'b1 && n < 100)
        begin
            @(negedge mclk_in);
            n++;
        end
        if (n == 100)
            bad_count++;
    endtask
    // ======================================================================
    // Main sequence
    initial
    begin
        forever #5 mclk_in = ~mclk_in;
    end
    initial
    begin
        repeat (20000) @(posedge mclk_in);
        bad_count++;
        test_done();
    end
    initial
    begin
        repeat (10) @(posedge mclk_in);
        rst_in <= 1'b0;
        rd(PORT_CTRL_ADDR, {30'h0, RMODE_RESET});
        wr(6'h3F, 32'hFFFFFFFF);
        rd(6'h3F, 32'h0);
        single_dest_reg_in <= 5'h3;
        // Last two rows differ only by rounding the product first
        for (int i = 0; i < 8; i++)
        begin
            wr(6'h01, (i < 6) ? 32'h40000000 : 32'h3F800800);
            wr(6'h02, (i < 6) ? 32'h40400000 : 32'h3F800800);
            wr(6'h03, (i < 6) ? 32'h3F800000 : 32'hBF800000);
            run(ffmlmu_op_t'((i < 6) ? i : (i - 6) * 4));
            rd(6'h03, EXP[i]);
        end
        single_dest_reg_in <= 5'h5;
        for (int i = 0; i < 32; i++)
        begin
            r = rnd();
            wr(6'h05, 32'h0);
            imm_in <= r[15:8];
            cmd_cond_in <= i[3:0];
            core_flags_in <= (i == 0) ? (r[3:0] & 4'hB) : r[3:0];
            run(OP_MOVE_IMM);
            rd(6'h05, pass(i[3:0], core_flags_in) ? fimm(r[15:8]) : 32'h0);
            rd(PORT_STAT_ADDR, {30'h0, ~pass(i[3:0], core_flags_in), 1'b0});
        end
        cmd_cond_in <= 4'hE;
        r = rnd();
        b = {r[31:2], 2'h0};
        base_register_in <= b;
        single_dest_reg_in <= 5'h8;
        list_count_in <= 6'h3;
        run(OP_BLOCK_REG_LOAD);
        chk(base_wb_data_out, b + 32'hC);
        for (int i = 0; i < 3; i++)
            rd(6'h08 + i[5:0], mv(b + 32'(4 * i)));
        r = rnd();
        b = {r[31:2], 2'h0};
        base_register_in <= b;
        increment_after_in <= 1'b0;
        double_dest_reg_in <= 4'h6;
        single_dest_reg_in <= 5'hC;
        cmd_double_in <= 1'b1;
        list_count_in <= 6'h2;
        slow <= 1'b1;
        run(OP_BLOCK_REG_LOAD);
        chk(base_wb_data_out, b - 32'h10);
        for (int i = 0; i < 4; i++)
            rd(6'h0C + i[5:0], mv(b - 32'h10 + 32'(4 * i)));
        double_dest_reg_in <= 4'hA;
        single_dest_reg_in <= 5'h14;
        imm_in <= 8'hFF;
        imm_add_in <= 1'b0;
        slow <= 1'b0;
        run(OP_SINGLE_REG_LOAD);
        rd(6'h14, mv(b - 32'h3FC));
        rd(6'h15, mv(b - 32'h3F8));
        double_source_reg_in <= 4'hA;
        double_dest_reg_in <= 4'h1;
        run(OP_MOVE_REG);
        rd(6'h02, mv(b - 32'h3FC));
        rd(6'h03, mv(b - 32'h3F8));
        rd(6'h14, mv(b - 32'h3FC));
        test_done();
    end
endmodule // testbench
bind ffmlmu_core ffmlmu_sva sva (.mclk_in, .rst_in, .cmd_valid_in, .cmd_op_in, .cmd_cond_in,
    .core_flags_in, .mem_rvalid_in, .cmd_ready_out, .done_out, .mem_req_out, .mem_addr_out,
    .base_wb_valid_out);
